// [hdl/pbw_regs.vh]
// Timing, reset and field constants for the push button wiper control
`ifndef PBW_REGS_VH
`define PBW_REGS_VH
`define PBW_POS_W          6
`define PBW_POS_MID        6'h20
`define PBW_POS_MAX        6'h3F
`define PBW_POS_MIN        6'h00
`define PBW_CLK_HZ         10000000
`define PBW_DEB_MS         8
`define PBW_SCAN_HOLD_MS   1000
`define PBW_SCAN_STEP_MS   140
`define PBW_IDLE_MS        1000
`define PBW_WRITE_MS       20
`define PBW_MS_TO_CYC(ms)  (((ms) * (`PBW_CLK_HZ / 1000)))
`define PBW_DEB_CYC        `PBW_MS_TO_CYC(`PBW_DEB_MS)
`define PBW_SCAN_HOLD_CYC  `PBW_MS_TO_CYC(`PBW_SCAN_HOLD_MS)
`define PBW_SCAN_STEP_CYC  `PBW_MS_TO_CYC(`PBW_SCAN_STEP_MS)
`define PBW_IDLE_CYC       `PBW_MS_TO_CYC(`PBW_IDLE_MS)
`define PBW_WRITE_CYC      `PBW_MS_TO_CYC(`PBW_WRITE_MS)
`endif

// [hdl/pbw_sync.v]
// Two-stage synchroniser for one pin input
`timescale 1ns/1ps
module pbw_sync (
    // Clock and control
    input  wire ref_clk_in,
    input  wire srst_in,
    input  wire ce_in,
    // Data
    input  wire d_in,
    output wire q_out
);
    reg s1_q;
    reg s2_q;

    // First stage feeds only the second
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else if (ce_in) begin
            s1_q <= d_in;
            s2_q <= s1_q;
        end
    end

    assign q_out = s2_q;
endmodule

// [hdl/pbw_nvm.v]
// Nonvolatile store for the wiper position, registered read
`timescale 1ns/1ps
`include "pbw_regs.vh"
module pbw_nvm #(
    parameter W = `PBW_POS_W
) (
    // Clock and control
    input  wire         ref_clk_in,
    input  wire         ce_in,
    // Write and read
    input  wire         we_in,
    input  wire [W-1:0] wdata_in,
    output reg  [W-1:0] rdata_out
);
    // Holds its content across reset, as stored cells would
    reg [W-1:0] cell_q;
    initial cell_q = `PBW_POS_MID;

    always @(posedge ref_clk_in) begin
        if (ce_in) begin
            if (we_in)
                cell_q <= wdata_in;
            rdata_out <= cell_q;
        end
    end
endmodule

// [hdl/pbw_top.v]
// Push button wiper control: debounce, scan, end-scale steps, save
// How it works
// - Wiper tap follows position register; 0x20 midscale
// - Six-bit position selects one of 64 taps
// - Up and down buttons are active high
// - Up pulses under 8 ms are ignored
// - Up held over 8 ms: one step up
// - Down mirrors up, stepping down
// - Held over 1 s: step every 140 ms
// - Past zero/full scale load bottom/top step
// - Bottom step ignores further down commands
// - Top step ignores further up commands
// - Save pin sampled at power-up; low auto
// - Auto mode: save after 1 s idle
// - Manual mode: save pin low 8 ms saves
// - Save lasts 20 ms, locks all inputs
// - Power-up loads position from stored value
// - Auto mode: drive save pin at end scale while a button is held
// - Indication persists until opposite move leaves end
// - Position register updates without limit
`timescale 1ns/1ps
`include "pbw_regs.vh"
module pbw_top #(
    parameter DEB_CYC       = `PBW_DEB_CYC,
    parameter SCAN_HOLD_CYC = `PBW_SCAN_HOLD_CYC,
    parameter SCAN_STEP_CYC = `PBW_SCAN_STEP_CYC,
    parameter IDLE_CYC      = `PBW_IDLE_CYC,
    parameter WRITE_CYC     = `PBW_WRITE_CYC
) (
    // Clock and control
    input  wire       ref_clk_in,
    input  wire       srst_in,
    input  wire       ce_in,
    // Buttons
    input  wire       step_up_button_in,
    input  wire       step_down_button_in,
    // Save pin, two-way
    input  wire       auto_save_enable_n_in,
    output wire       auto_save_enable_n_out,
    output wire       auto_save_enable_n_oe_out,
    // Wiper
    output reg  [5:0] wiper_tap_out,
    output reg        bottom_scale_step_out,
    output reg        top_scale_step_out,
    output wire       store_busy_out
);
    // Counter width: the longest interval, one second of reference clock,
    // fits in 24 bits; a faster reference clock needs a wider counter here
    localparam CW = 24;
    // One-hot power-up sequence
    localparam ST_LOAD = 3'b001;
    localparam ST_RUN  = 3'b010;
    localparam ST_WR   = 3'b100;

    wire up_s;
    wire dn_s;
    wire ase_s;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    pbw_sync u_sync_up (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .ce_in      (ce_in),
        .d_in       (step_up_button_in),
        .q_out      (up_s)
    );
    pbw_sync u_sync_dn (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .ce_in      (ce_in),
        .d_in       (step_down_button_in),
        .q_out      (dn_s)
    );
    pbw_sync u_sync_ase (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .ce_in      (ce_in),
        .d_in       (auto_save_enable_n_in),
        .q_out      (ase_s)
    );

    ////////////////////////////////////////////////////////////////////////
    // State
    reg [2:0]    st_q;
    reg [1:0]    load_cnt_q;
    reg          auto_mode_q;
    reg [5:0]    pos_q;
    reg          bs_q;
    reg          ts_q;
    reg [CW-1:0] up_cnt_q;
    reg [CW-1:0] dn_cnt_q;
    reg          up_scan_q;
    reg          dn_scan_q;
    reg [CW-1:0] idle_cnt_q;
    reg [CW-1:0] man_cnt_q;
    reg          man_done_q;
    reg [CW-1:0] wr_cnt_q;
    reg          dirty_q;
    reg          nvm_we;
    wire [5:0]   nvm_rdata;

    wire lock  = (st_q != ST_RUN);
    wire up_a  = up_s & ~dn_s;
    wire dn_a  = dn_s & ~up_s;
    // Indicator is decoded from the visible flags in the same cycle they change,
    // so the pin drive and the flag outputs always agree when sampled
    wire end_s = bottom_scale_step_out | top_scale_step_out;

    // Step strobes: first after debounce, then scan repeats; the first-step
    // compare is masked in scan so a held button never steps at both counts
    wire up_first = up_a && !up_scan_q && up_cnt_q == DEB_CYC[CW-1:0];
    wire dn_first = dn_a && !dn_scan_q && dn_cnt_q == DEB_CYC[CW-1:0];
    wire up_rep   = up_a && up_scan_q && up_cnt_q == SCAN_STEP_CYC[CW-1:0];
    wire dn_rep   = dn_a && dn_scan_q && dn_cnt_q == SCAN_STEP_CYC[CW-1:0];
    wire up_step  = ~lock & (up_first | up_rep);
    wire dn_step  = ~lock & (dn_first | dn_rep);

    // Manual store fires once per low hold of the save pin
    wire man_save  = ~lock & ~auto_mode_q & ~ase_s & ~man_done_q
                     & (man_cnt_q == DEB_CYC[CW-1:0]);
    wire auto_save = ~lock & auto_mode_q & dirty_q & ~up_s & ~dn_s
                     & (idle_cnt_q == IDLE_CYC[CW-1:0]);

    ////////////////////////////////////////////////////////////////////////
    // Stored position memory
    pbw_nvm #(.W(6)) u_nvm (
        .ref_clk_in (ref_clk_in),
        .ce_in      (ce_in),
        .we_in      (nvm_we),
        .wdata_in   (pos_q),
        .rdata_out  (nvm_rdata)
    );

    // Only one save source is live: the mode bit picks auto or manual.
    // A step and a manual save may meet in one cycle; the write then keeps
    // the old position, and the new one needs another store.
    always @* begin
        nvm_we = man_save | auto_save;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequence: load from store, run, write lock
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            st_q        <= ST_LOAD;
            load_cnt_q  <= 2'h0;
            auto_mode_q <= 1'b0;
            wr_cnt_q    <= {CW{1'b0}};
        end else if (ce_in) begin
            case (st_q)
                ST_LOAD: begin
                    // Waits for synchroniser and registered read to settle
                    load_cnt_q <= load_cnt_q + 2'h1;
                    if (load_cnt_q == 2'h3) begin
                        auto_mode_q <= ~ase_s;
                        st_q        <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (nvm_we) begin
                        wr_cnt_q <= {CW{1'b0}};
                        st_q     <= ST_WR;
                    end
                end
                ST_WR: begin
                    // Lock lasts WRITE_CYC cycles; all timers stay cleared meanwhile
                    wr_cnt_q <= wr_cnt_q + {{(CW-1){1'b0}}, 1'b1};
                    if (wr_cnt_q == WRITE_CYC[CW-1:0] - 1'b1)
                        st_q <= ST_RUN;
                end
                default: st_q <= ST_LOAD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Debounce and scan timers; cleared while locked so presses are dropped
    // Both buttons held together count as neither, so a rolled press never
    // steps; the scan hold is timed from the first contact, debounce count included
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            up_cnt_q  <= {CW{1'b0}};
            dn_cnt_q  <= {CW{1'b0}};
            up_scan_q <= 1'b0;
            dn_scan_q <= 1'b0;
        end else if (ce_in) begin
            if (lock || !up_a) begin
                up_cnt_q  <= {CW{1'b0}};
                up_scan_q <= 1'b0;
            end else if (up_rep) begin
                // Scan repeat restarts the step interval
                up_cnt_q  <= {CW{1'b0}};
            end else if (!up_scan_q && up_cnt_q == SCAN_HOLD_CYC[CW-1:0]) begin
                up_scan_q <= 1'b1;
                up_cnt_q  <= {CW{1'b0}};
            end else begin
                up_cnt_q  <= up_cnt_q + {{(CW-1){1'b0}}, 1'b1};
            end
            if (lock || !dn_a) begin
                dn_cnt_q  <= {CW{1'b0}};
                dn_scan_q <= 1'b0;
            end else if (dn_rep) begin
                // Scan repeat restarts the step interval
                dn_cnt_q  <= {CW{1'b0}};
            end else if (!dn_scan_q && dn_cnt_q == SCAN_HOLD_CYC[CW-1:0]) begin
                dn_scan_q <= 1'b1;
                dn_cnt_q  <= {CW{1'b0}};
            end else begin
                dn_cnt_q  <= dn_cnt_q + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Position register with end-scale extra steps; no update limit
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            pos_q <= `PBW_POS_MID;
            bs_q  <= 1'b0;
            ts_q  <= 1'b0;
        end else if (ce_in) begin
            if (st_q == ST_LOAD) begin
                pos_q <= nvm_rdata;
                bs_q  <= 1'b0;
                ts_q  <= 1'b0;
            end else if (up_step) begin
                if (bs_q)
                    bs_q <= 1'b0;
                else if (ts_q)
                    ts_q <= 1'b1;
                else if (pos_q == `PBW_POS_MAX)
                    ts_q <= 1'b1;
                else
                    pos_q <= pos_q + 6'h01;
            end else if (dn_step) begin
                if (ts_q)
                    ts_q <= 1'b0;
                else if (bs_q)
                    bs_q <= 1'b1;
                else if (pos_q == `PBW_POS_MIN)
                    bs_q <= 1'b1;
                else
                    pos_q <= pos_q - 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Idle and manual store timers
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            idle_cnt_q <= {CW{1'b0}};
            man_cnt_q  <= {CW{1'b0}};
            man_done_q <= 1'b0;
            dirty_q    <= 1'b0;
        end else if (ce_in) begin
            // Any button activity restarts the idle wait
            if (lock || up_s || dn_s)
                idle_cnt_q <= {CW{1'b0}};
            else if (idle_cnt_q != IDLE_CYC[CW-1:0])
                idle_cnt_q <= idle_cnt_q + {{(CW-1){1'b0}}, 1'b1};
            // Set wins: a step during a save marks it dirty again
            if (up_step || dn_step)
                dirty_q <= 1'b1;
            else if (nvm_we)
                dirty_q <= 1'b0;
            if (lock || auto_mode_q || ase_s) begin
                man_cnt_q <= {CW{1'b0}};
                if (ase_s)
                    man_done_q <= 1'b0;
            end else if (man_cnt_q != DEB_CYC[CW-1:0]) begin
                man_cnt_q <= man_cnt_q + {{(CW-1){1'b0}}, 1'b1};
            end else begin
                man_done_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs: tap register and end-scale indicator
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            wiper_tap_out         <= `PBW_POS_MID;
            bottom_scale_step_out <= 1'b0;
            top_scale_step_out    <= 1'b0;
        end else if (ce_in) begin
            wiper_tap_out         <= pos_q;
            bottom_scale_step_out <= bs_q;
            top_scale_step_out    <= ts_q;
        end
    end

    // Pin driven high only in auto mode while a button is held at an end
    assign auto_save_enable_n_out    = 1'b1;
    assign auto_save_enable_n_oe_out = auto_mode_q & (st_q != ST_LOAD)
                                       & end_s & (up_s | dn_s);
    assign store_busy_out            = (st_q == ST_WR);
endmodule

// [sim/pbw_btn_model.sv]
// Push buttons, store button and pull resistor around the device pins
`timescale 1ns/1ps
module pbw_btn_model (
    // Requests from the bench
    input  wire up_press_in,
    input  wire dn_press_in,
    input  wire store_press_in,
    input  wire pull_high_in,
    // Save pin drive from the device
    input  wire drv_in,
    input  wire oe_in,
    // Pin levels seen by the device
    output wire up_out,
    output wire dn_out,
    output wire pin_out
);
    // Closed contact drives high; an open one falls to the internal pull-down
    assign up_out  = up_press_in;
    assign dn_out  = dn_press_in;
    // Device drive wins, else the store button overpowers the pull resistor
    assign pin_out = oe_in ? drv_in : (store_press_in ? 1'h0 : pull_high_in);
endmodule

// [sim/pbw_top_assertions.sv]
// Port level checks for the push button wiper control
`timescale 1ns/1ps
module pbw_top_chk #(
    parameter DEB_CYC       = 8,
    parameter SCAN_HOLD_CYC = 40,
    parameter SCAN_STEP_CYC = 12,
    parameter IDLE_CYC      = 50,
    parameter WRITE_CYC     = 10
) (
    // Clock and reset
    input wire       ref_clk_in,
    input wire       srst_in,
    // Watched ports
    input wire       step_up_button_in,
    input wire       step_down_button_in,
    input wire       auto_save_enable_n_out,
    input wire       auto_save_enable_n_oe_out,
    input wire [5:0] wiper_tap_out,
    input wire       bottom_scale_step_out,
    input wire       top_scale_step_out,
    input wire       store_busy_out
);
    reg [3:0]  set_q;
    reg [15:0] bcnt_q;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    ////////////////////////////////////////////////////////////////
    // Settle counter masks the load jump after reset; busy run length
    always @(posedge ref_clk_in) begin
        set_q  <= srst_in ? 4'h0 : ((set_q == 4'hF) ? set_q : set_q + 4'h1);
        bcnt_q <= store_busy_out ? bcnt_q + 16'h1 : 16'h0;
    end
    ////////////////////////////////////////////////////////////////
    sequence s_quiet_dn; (!step_down_button_in)[*8]; endsequence
    sequence s_busy_run; store_busy_out[*2]; endsequence
    // Reset value shows for two edges, then the stored position arrives
    property p_rst_mid; $fell(srst_in) |-> (wiper_tap_out == 6'h20)[*2]; endproperty
    property p_one_step; (set_q == 4'hF) && $changed(wiper_tap_out) |->
        (wiper_tap_out == $past(wiper_tap_out) + 6'h01) || (wiper_tap_out == $past(wiper_tap_out) - 6'h01); endproperty
    property p_debounced; (set_q == 4'hF) && $changed(wiper_tap_out) |->
        ($past(step_up_button_in, 6) && $past(step_up_button_in, 10)) ||
        ($past(step_down_button_in, 6) && $past(step_down_button_in, 10)); endproperty
    property p_bot_zero; bottom_scale_step_out |-> wiper_tap_out == 6'h00; endproperty
    property p_top_full; top_scale_step_out |-> wiper_tap_out == 6'h3F; endproperty
    property p_top_hold; s_quiet_dn ##0 top_scale_step_out |=> top_scale_step_out; endproperty
    property p_flags_excl; !(top_scale_step_out && bottom_scale_step_out); endproperty
    property p_oe_cause; auto_save_enable_n_oe_out |->
        auto_save_enable_n_out && (top_scale_step_out || bottom_scale_step_out); endproperty
    property p_oe_button; auto_save_enable_n_oe_out |-> $past(step_up_button_in, 2) ||
        $past(step_down_button_in, 2) || $past(step_up_button_in, 3) || $past(step_down_button_in, 3); endproperty
    property p_busy_len; $fell(store_busy_out) |-> (bcnt_q >= WRITE_CYC) && (bcnt_q <= WRITE_CYC + 1); endproperty
    property p_lock_tap; s_busy_run |-> $stable(wiper_tap_out); endproperty
    a_rst_mid: assert property (p_rst_mid) else $error("tap not midscale after reset");
    a_one_step: assert property (p_one_step) else $error("tap moved by more than one");
    a_debounced: assert property (p_debounced) else $error("tap moved without debounced press");
    a_bot_zero: assert property (p_bot_zero) else $error("bottom step away from zero");
    a_top_full: assert property (p_top_full) else $error("top step away from full scale");
    a_top_hold: assert property (p_top_hold) else $error("top step lost without down press");
    a_flags_excl: assert property (p_flags_excl) else $error("both end steps active");
    a_oe_cause: assert property (p_oe_cause) else $error("indicator driven off end scale");
    a_oe_button: assert property (p_oe_button) else $error("indicator with no button active");
    a_busy_len: assert property (p_busy_len) else $error("write lock length wrong");
    a_lock_tap: assert property (p_lock_tap) else $error("tap moved during write lock");
endmodule
bind pbw_top pbw_top_chk #(.DEB_CYC(DEB_CYC), .SCAN_HOLD_CYC(SCAN_HOLD_CYC), .SCAN_STEP_CYC(SCAN_STEP_CYC),
    .IDLE_CYC(IDLE_CYC), .WRITE_CYC(WRITE_CYC)) pbw_top_chk_inst (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .step_up_button_in(step_up_button_in), .step_down_button_in(step_down_button_in),
    .auto_save_enable_n_out(auto_save_enable_n_out), .auto_save_enable_n_oe_out(auto_save_enable_n_oe_out),
    .wiper_tap_out(wiper_tap_out), .bottom_scale_step_out(bottom_scale_step_out),
    .top_scale_step_out(top_scale_step_out), .store_busy_out(store_busy_out));

// [sim/tb_top.sv]
// Self-checking testbench for the push button wiper control
`timescale 1ns/1ps
module tb_top;
    reg        clk, rst, ce, up, dn, st, ph;
    wire       up_w, dn_w, ase_w, drv, oe, bsy, bot, top;
    wire [5:0] tap;
    integer    miscompares, checked, i, n, k, t0, t1, b0;
    integer    nb = 0;
    reg [31:0] seed;
    reg [5:0]  exp;
    ////////////////////////////////////////////////////////////////
    // Clock, design with short counts, button model
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    pbw_top #(.DEB_CYC(8), .SCAN_HOLD_CYC(40), .SCAN_STEP_CYC(12), .IDLE_CYC(50), .WRITE_CYC(10)) pbw_top_inst (
        .ref_clk_in(clk), .srst_in(rst), .ce_in(ce), .step_up_button_in(up_w), .step_down_button_in(dn_w),
        .auto_save_enable_n_in(ase_w), .auto_save_enable_n_out(drv), .auto_save_enable_n_oe_out(oe),
        .wiper_tap_out(tap), .bottom_scale_step_out(bot), .top_scale_step_out(top), .store_busy_out(bsy));
    pbw_btn_model pbw_btn_model_inst (.up_press_in(up), .dn_press_in(dn), .store_press_in(st),
        .pull_high_in(ph), .drv_in(drv), .oe_in(oe), .up_out(up_w), .dn_out(dn_w), .pin_out(ase_w));
    // Count write lock cycles; one save shows as one full lock length
    always @(posedge clk) if (bsy === 1'h1) nb <= nb + 1;
    ////////////////////////////////////////////////////////////////
    function [31:0] xs(input [31:0] v);
        reg [31:0] x;
        begin
            x = v ^ (v << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    // Expected position after one debounced step, clamped at the ends
    function [5:0] step(input [5:0] p, input d);
        step = d ? ((p == 6'h3F) ? p : p + 6'h01) : ((p == 6'h00) ? p : p - 6'h01);
    endfunction
    task chk(input [15:0] got, input [15:0] want);
        begin
            checked = checked + 1;
            if (got !== want) begin
                miscompares = miscompares + 1;
                $display("BAD t=%0t got=%h want=%h", $time, got, want);
            end
        end
    endtask
    task cyc(input integer c);
        repeat (c) @(posedge clk);
    endtask
    // Hold one button for c cycles, then leave time for the step to show
    task press(input d, input integer c);
        begin
            @(posedge clk);
            if (d) up <= 1'h1;
            else dn <= 1'h1;
            cyc(c);
            up <= 1'h0;
            dn <= 1'h0;
            cyc(12);
            @(negedge clk);
        end
    endtask
    task rstp;
        begin
            @(posedge clk);
            rst <= 1'h1;
            cyc(2);
            rst <= 1'h0;
            cyc(10);
            @(negedge clk);
        end
    endtask
    task wbusy(input integer c);
        begin
            n = 0;
            while (bsy !== 1'h1 && n < c) begin
                @(posedge clk);
                #1 n = n + 1;
            end
            chk(bsy, 1'h1);
            if (bsy !== 1'h1) conclude;
        end
    endtask
    task conclude;
        begin
            $display("Comparisons %0d mismatches %0d", checked, miscompares);
            if (miscompares == 0 && checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'h1; up = 1'h0; dn = 1'h0; st = 1'h0; ph = 1'h0; ce = 1'h1;
        miscompares = 0; checked = 0; seed = 32'hDE4F1C03;
        cyc(2);
        rst <= 1'h0;
        cyc(10);
        @(negedge clk);
        chk(tap, 6'h20);
        exp = 6'h20;
        // Random bounces and real presses near midscale
        for (i = 0; i < 12; i = i + 1) begin
            seed = xs(seed);
            n = seed[3] ? 14 + seed[2:0] : 2 + seed[1:0];
            press(seed[4], n);
            if (n > 13) exp = step(exp, seed[4]);
            chk(tap, exp);
        end
        b0 = nb;
        cyc(70);
        chk(nb - b0, 8'h0A);
        // A press inside the write lock is dropped
        press(1'h1, 14);
        exp = step(exp, 1'h1);
        wbusy(80);
        @(posedge clk);
        up <= 1'h1;
        cyc(12);
        up <= 1'h0;
        cyc(12);
        @(negedge clk);
        chk(tap, exp);
        // Scan down into the bottom step, timing the repeat period
        @(posedge clk);
        dn <= 1'h1;
        exp = tap;
        k = 0;
        repeat (700) begin
            @(posedge clk);
            #1;
            if (tap !== exp) begin
                k = k + 1;
                if (k == 3) t0 = $time;
                if (k == 4) t1 = $time;
                exp = tap;
            end
        end
        chk((t1 - t0) / 100, 13);
        chk({oe, bot, drv, tap}, 9'h1C0);
        @(posedge clk);
        dn <= 1'h0;
        cyc(4);
        @(negedge clk);
        chk({oe, bot}, 2'h1);
        press(1'h0, 14);
        chk({bot, tap}, 7'h40);
        press(1'h1, 14);
        chk({bot, tap}, 7'h00);
        // Scan up into the top step
        @(posedge clk);
        up <= 1'h1;
        cyc(1000);
        @(negedge clk);
        chk({top, tap, oe}, 8'hFF);
        @(posedge clk);
        up <= 1'h0;
        press(1'h0, 14);
        chk({top, tap}, 7'h3F);
        cyc(80);
        // Manual save mode after a fresh power-up
        ph <= 1'h1;
        rstp;
        chk(tap, 6'h3F);
        press(1'h0, 14);
        chk(tap, 6'h3E);
        b0 = nb;
        @(posedge clk);
        st <= 1'h1;
        cyc(4);
        st <= 1'h0;
        cyc(70);
        @(negedge clk);
        chk(nb - b0, 8'h00);
        b0 = nb;
        @(posedge clk);
        st <= 1'h1;
        cyc(16);
        st <= 1'h0;
        cyc(10);
        @(negedge clk);
        chk(nb - b0, 8'h0A);
        press(1'h1, 14);
        cyc(70);
        rstp;
        chk(tap, 6'h3E);
        // Clock enable low freezes the block, so a long press is never seen
        @(posedge clk);
        ce <= 1'h0;
        press(1'h1, 14);
        @(posedge clk);
        ce <= 1'h1;
        cyc(4);
        @(negedge clk);
        chk(tap, 6'h3E);
        conclude;
    end
endmodule
